//--- design/bay_pkg.sv
// Shared constants for the bay hot-plug state machine and its APB registers
// ==========================================================================
package bay_pkg;

	// ======================================================================
	// Register byte offsets
	localparam logic [7:0] STATUS_OFF    = 8'h00;
	localparam logic [7:0] CONTROL_OFF   = 8'h04;
	localparam logic [7:0] IRQ_STS_OFF   = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFF  = 8'h0c;
	localparam logic [7:0] STATE_OFF     = 8'h10;

	// ======================================================================
	// Field positions
	localparam int STS_SER_BIT    = 0;
	localparam int STS_FW_BIT     = 1;
	localparam int STS_DSC_BIT    = 2;
	localparam int STS_RRQ_BIT    = 3;
	localparam int CTL_DSC_EN_BIT = 2;
	localparam int CTL_RRQ_EN_BIT = 3;
	localparam int CTL_REQ_LSB    = 4;
	localparam int CTL_REQ_MSB    = 6;
	localparam int IRQ_DSC_BIT    = 0;
	localparam int IRQ_RRQ_BIT    = 1;
	localparam int IRQ_RMV_BIT    = 2;
	localparam int IRQ_W          = 3;

	// ======================================================================
	// State codes as seen by software
	localparam logic [2:0] CODE_EMPTY    = 3'h0;
	localparam logic [2:0] CODE_INSERTED = 3'h1;
	localparam logic [2:0] CODE_ENABLED  = 3'h2;
	localparam logic [2:0] CODE_REMREQ   = 3'h3;
	localparam logic [2:0] CODE_ALLOWED  = 3'h4;
	localparam logic [2:0] CODE_DEBOUNCE = 3'h5;

	// ======================================================================
	// Reset values and counts
	localparam logic [2:0]     CTL_REQ_RST    = 3'h0;
	localparam logic [IRQ_W-1:0] IRQ_RST      = 3'h0;
	localparam int             DEBOUNCE_CYCLES = 1000;

endpackage : bay_pkg

//--- design/bay_state_machine.sv
// Per-bay hot-plug state machine with APB registers and interrupt
`timescale 1ns/100ps

module bay_state_machine #(
	parameter int DEBOUNCE_CYCLES = bay_pkg::DEBOUNCE_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        serial_device_present_i,
	input  wire logic        firewire_device_present_i,
	input  wire logic        remove_btn_i,
	output logic      [2:0]  bay_state_o,
	output logic             irq_o
);

	typedef enum logic [2:0] {
		ST_EMPTY, ST_DEBOUNCE, ST_INSERTED, ST_ENABLED, ST_REMREQ, ST_ALLOWED
	} bay_st_t;

	// ======================================================================
	// Code helpers
	function automatic logic [2:0] state_code(input bay_st_t s);
		case (s)
			ST_EMPTY:    state_code = bay_pkg::CODE_EMPTY;
			ST_DEBOUNCE: state_code = bay_pkg::CODE_DEBOUNCE;
			ST_INSERTED: state_code = bay_pkg::CODE_INSERTED;
			ST_ENABLED:  state_code = bay_pkg::CODE_ENABLED;
			ST_REMREQ:   state_code = bay_pkg::CODE_REMREQ;
			ST_ALLOWED:  state_code = bay_pkg::CODE_ALLOWED;
			default:     state_code = bay_pkg::CODE_EMPTY;
		endcase
	endfunction : state_code

	// Only codes 1..4 name a target; empty and debounce are never targets
	function automatic logic code_valid(input logic [2:0] c);
		code_valid = (c == bay_pkg::CODE_INSERTED) ||
		             (c == bay_pkg::CODE_ENABLED)  ||
		             (c == bay_pkg::CODE_REMREQ)   ||
		             (c == bay_pkg::CODE_ALLOWED);
	endfunction : code_valid

	function automatic bay_st_t code_state(input logic [2:0] c);
		case (c)
			bay_pkg::CODE_INSERTED: code_state = ST_INSERTED;
			bay_pkg::CODE_ENABLED:  code_state = ST_ENABLED;
			bay_pkg::CODE_REMREQ:   code_state = ST_REMREQ;
			bay_pkg::CODE_ALLOWED:  code_state = ST_ALLOWED;
			default:                code_state = ST_INSERTED;
		endcase
	endfunction : code_state

	// ======================================================================
	// Pin synchronisation and edge detection
	logic [2:0] pin_sync;
	logic       present_ff;
	logic       btn_ff;
	logic       present_now;
	logic       pres_rise;
	logic       pres_fall;
	logic       btn_rise;
	logic       tmr_done;

	sync_2ff #(.W(3)) u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({remove_btn_i, firewire_device_present_i, serial_device_present_i}),
		.sync_o    (pin_sync)
	);

	// Either presence bit counts as a device in the bay
	assign present_now = pin_sync[0] | pin_sync[1];
	assign pres_rise   = present_now & ~present_ff;
	assign pres_fall   = ~present_now & present_ff;
	assign btn_rise    = pin_sync[2] & ~btn_ff;

	// ======================================================================
	// APB slave: one wait state so that every output is registered
	logic        acc_done;
	logic        wr_en;
	logic        wr_sts;
	logic        wr_ctl;
	logic        wr_irqs;
	logic        wr_irqm;
	logic        sw_go;
	logic [2:0]  wr_code;
	logic        nxt_pready;
	logic        nxt_slverr;
	logic [31:0] nxt_prdata;

	assign acc_done = psel_i & penable_i & pready_o;
	assign wr_en    = acc_done & pwrite_i;
	assign wr_sts   = wr_en & (paddr_i == bay_pkg::STATUS_OFF);
	assign wr_ctl   = wr_en & (paddr_i == bay_pkg::CONTROL_OFF);
	assign wr_irqs  = wr_en & (paddr_i == bay_pkg::IRQ_STS_OFF);
	assign wr_irqm  = wr_en & (paddr_i == bay_pkg::IRQ_MASK_OFF);
	assign wr_code  = pwdata_i[bay_pkg::CTL_REQ_MSB:bay_pkg::CTL_REQ_LSB];
	// The write itself is the request; the stored field only reads back
	assign sw_go    = wr_ctl & present_now & code_valid(wr_code);

	// ======================================================================
	// Control and status registers
	bay_st_t          st_ff;
	bay_st_t          nxt_st;
	logic             dsc_en_ff;
	logic             rrq_en_ff;
	logic [2:0]       req_ff;
	logic             dsc_flag_ff;
	logic             rrq_flag_ff;
	logic [bay_pkg::IRQ_W-1:0] irq_sts_ff;
	logic [bay_pkg::IRQ_W-1:0] irq_mask_ff;
	logic             nxt_dsc_en;
	logic             nxt_rrq_en;
	logic [2:0]       nxt_req;
	logic             nxt_dsc_flag;
	logic             nxt_rrq_flag;
	logic [bay_pkg::IRQ_W-1:0] nxt_irq_sts;
	logic [bay_pkg::IRQ_W-1:0] nxt_irq_mask;
	logic [bay_pkg::IRQ_W-1:0] irq_ev;
	logic             dsc_set;

	// Read mux and bus answer
	always_comb begin
		nxt_pready = psel_i & penable_i & ~pready_o;
		nxt_slverr = 1'b0;
		nxt_prdata = 32'h0;
		case (paddr_i)
			bay_pkg::STATUS_OFF: begin
				nxt_prdata[bay_pkg::STS_SER_BIT] = pin_sync[0];
				nxt_prdata[bay_pkg::STS_FW_BIT]  = pin_sync[1];
				nxt_prdata[bay_pkg::STS_DSC_BIT] = dsc_flag_ff;
				nxt_prdata[bay_pkg::STS_RRQ_BIT] = rrq_flag_ff;
			end
			bay_pkg::CONTROL_OFF: begin
				nxt_prdata[bay_pkg::CTL_DSC_EN_BIT] = dsc_en_ff;
				nxt_prdata[bay_pkg::CTL_RRQ_EN_BIT] = rrq_en_ff;
				nxt_prdata[bay_pkg::CTL_REQ_MSB:bay_pkg::CTL_REQ_LSB] = req_ff;
			end
			bay_pkg::IRQ_STS_OFF:  nxt_prdata[bay_pkg::IRQ_W-1:0] = irq_sts_ff;
			bay_pkg::IRQ_MASK_OFF: nxt_prdata[bay_pkg::IRQ_W-1:0] = irq_mask_ff;
			bay_pkg::STATE_OFF:    nxt_prdata[2:0] = state_code(st_ff);
			default:               nxt_slverr = 1'b1;
		endcase
		if (!nxt_pready) begin
			nxt_prdata = 32'h0;
			nxt_slverr = 1'b0;
		end
	end

	// ======================================================================
	// Bay state machine: fall first, then software, then other hardware
	always_comb begin
		nxt_st  = st_ff;
		dsc_set = 1'b0;
		if (pres_fall)
			nxt_st = ST_EMPTY;
		else if (sw_go)
			nxt_st = code_state(wr_code);
		else begin
			case (st_ff)
				ST_EMPTY:
					if (pres_rise && dsc_en_ff)
						nxt_st = ST_DEBOUNCE;
				ST_DEBOUNCE:
					if (tmr_done && present_now && dsc_en_ff) begin
						nxt_st  = ST_INSERTED;
						dsc_set = 1'b1;
					end
				ST_INSERTED, ST_ENABLED:
					if (rrq_flag_ff && rrq_en_ff)
						nxt_st = ST_REMREQ;
				default: nxt_st = st_ff;
			endcase
		end
	end

	debounce_timer #(.CYCLES(DEBOUNCE_CYCLES)) u_tmr (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (st_ff == ST_DEBOUNCE),
		.done_o    (tmr_done)
	);

	// Register next values; a set in the clearing cycle wins
	always_comb begin
		irq_ev = '0;
		irq_ev[bay_pkg::IRQ_DSC_BIT] = dsc_set;
		irq_ev[bay_pkg::IRQ_RRQ_BIT] = btn_rise;
		irq_ev[bay_pkg::IRQ_RMV_BIT] = pres_fall;
		nxt_dsc_en   = wr_ctl ? pwdata_i[bay_pkg::CTL_DSC_EN_BIT] : dsc_en_ff;
		nxt_rrq_en   = wr_ctl ? pwdata_i[bay_pkg::CTL_RRQ_EN_BIT] : rrq_en_ff;
		nxt_req      = wr_ctl ? wr_code : req_ff;
		nxt_dsc_flag = (dsc_flag_ff &
		               ~(wr_sts & pwdata_i[bay_pkg::STS_DSC_BIT])) | dsc_set;
		nxt_rrq_flag = (rrq_flag_ff &
		               ~(wr_sts & pwdata_i[bay_pkg::STS_RRQ_BIT])) | btn_rise;
		nxt_irq_sts  = (irq_sts_ff &
		               ~(wr_irqs ? pwdata_i[bay_pkg::IRQ_W-1:0] : '0)) | irq_ev;
		nxt_irq_mask = wr_irqm ? pwdata_i[bay_pkg::IRQ_W-1:0] : irq_mask_ff;
	end

	// Reset puts the bay empty with no flag even if a device sits there
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_ff       <= ST_EMPTY;
			present_ff  <= 1'b0;
			btn_ff      <= 1'b0;
			dsc_en_ff   <= 1'b0;
			rrq_en_ff   <= 1'b0;
			req_ff      <= bay_pkg::CTL_REQ_RST;
			dsc_flag_ff <= 1'b0;
			rrq_flag_ff <= 1'b0;
			irq_sts_ff  <= bay_pkg::IRQ_RST;
			irq_mask_ff <= bay_pkg::IRQ_RST;
			prdata_o    <= 32'h0;
			pready_o    <= 1'b0;
			pslverr_o   <= 1'b0;
			bay_state_o <= bay_pkg::CODE_EMPTY;
			irq_o       <= 1'b0;
		end else begin
			st_ff       <= nxt_st;
			present_ff  <= present_now;
			btn_ff      <= pin_sync[2];
			dsc_en_ff   <= nxt_dsc_en;
			rrq_en_ff   <= nxt_rrq_en;
			req_ff      <= nxt_req;
			dsc_flag_ff <= nxt_dsc_flag;
			rrq_flag_ff <= nxt_rrq_flag;
			irq_sts_ff  <= nxt_irq_sts;
			irq_mask_ff <= nxt_irq_mask;
			prdata_o    <= nxt_prdata;
			pready_o    <= nxt_pready;
			pslverr_o   <= nxt_slverr;
			bay_state_o <= state_code(nxt_st);
			irq_o       <= |(nxt_irq_sts & nxt_irq_mask);
		end
	end

	// ======================================================================
	// Checks
	sequence s_sw_req;
		wr_ctl && present_now && code_valid(wr_code);
	endsequence

	sequence s_debounce_done;
		st_ff == ST_DEBOUNCE && tmr_done && present_now && dsc_en_ff;
	endsequence

	property p_insert;
		@(posedge clk_i) disable iff (sys_rst_i)
		(st_ff == ST_EMPTY && pres_rise && dsc_en_ff && !sw_go)
		|=> st_ff == ST_DEBOUNCE;
	endproperty
	a_insert: assert property (p_insert)
		else $error("insertion did not start debounce");

	property p_debounce_fall;
		@(posedge clk_i) disable iff (sys_rst_i)
		(st_ff == ST_DEBOUNCE && pres_fall) |=> st_ff == ST_EMPTY;
	endproperty
	a_debounce_fall: assert property (p_debounce_fall)
		else $error("removal during debounce not back to empty");

	property p_inserted_flag;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_debounce_done ##0 !sw_go)
		|=> (st_ff == ST_INSERTED && dsc_flag_ff && bay_state_o == 3'h1);
	endproperty
	a_inserted_flag: assert property (p_inserted_flag)
		else $error("debounce expiry did not insert and flag");

	property p_fall_empty;
		@(posedge clk_i) disable iff (sys_rst_i)
		pres_fall |=> (st_ff == ST_EMPTY && bay_state_o == 3'h0);
	endproperty
	a_fall_empty: assert property (p_fall_empty)
		else $error("device removal did not empty the bay");

	property p_remreq;
		@(posedge clk_i) disable iff (sys_rst_i)
		((st_ff == ST_INSERTED || st_ff == ST_ENABLED) && rrq_flag_ff &&
		 rrq_en_ff && !pres_fall && !sw_go) |=> st_ff == ST_REMREQ;
	endproperty
	a_remreq: assert property (p_remreq)
		else $error("removal request not taken");

	property p_disabled_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		((st_ff == ST_EMPTY || st_ff == ST_DEBOUNCE) && !dsc_en_ff &&
		 !sw_go && !pres_fall) |=> $stable(st_ff);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold)
		else $error("hardware move while change enable clear");

	property p_ignore_absent;
		@(posedge clk_i) disable iff (sys_rst_i)
		(wr_ctl && !present_now && !pres_fall) |=> $stable(st_ff);
	endproperty
	a_ignore_absent: assert property (p_ignore_absent)
		else $error("request write acted on an empty bay");

	property p_sw_target;
		@(posedge clk_i) disable iff (sys_rst_i)
		s_sw_req |=> (state_code(st_ff) == $past(wr_code) &&
		              st_ff != ST_EMPTY && st_ff != ST_DEBOUNCE);
	endproperty
	a_sw_target: assert property (p_sw_target)
		else $error("request write did not reach its target");

	property p_reset_empty;
		@(posedge clk_i)
		sys_rst_i |=> (st_ff == ST_EMPTY && !dsc_flag_ff && !irq_o);
	endproperty
	a_reset_empty: assert property (p_reset_empty)
		else $error("reset did not empty the bay");

	property p_pready_pulse;
		@(posedge clk_i) disable iff (sys_rst_i)
		(psel_i && penable_i && !pready_o) |=> pready_o ##1 !pready_o;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse)
		else $error("pready not a single cycle after one wait");

endmodule : bay_state_machine

//--- design/debounce_timer.sv
// Debounce timer that raises a level once it has run its full length
`timescale 1ns/100ps

module debounce_timer #(
	parameter int CYCLES = bay_pkg::DEBOUNCE_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic run_i,
	output logic      done_o
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES);

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;

	// ======================================================================
	// Count while running, hold at the end, restart when stopped
	always_comb begin
		nxt_cnt = cnt_ff;
		if (!run_i)
			nxt_cnt = '0;
		else if (cnt_ff != LAST)
			nxt_cnt = cnt_ff + CW'(1);
	end

	assign done_o = (cnt_ff == LAST);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	// ======================================================================
	// Checks
	property p_done_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		(done_o && run_i) |=> done_o;
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("debounce done dropped while running");

endmodule : debounce_timer

//--- design/sync_2ff.sv
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps

module sync_2ff #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	// ======================================================================
	// Next values; first stage feeds only the second stage
	always_comb begin
		nxt_meta = async_i;
		nxt_sync = meta_ff;
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_ff <= '0;
			sync_o  <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_o  <= nxt_sync;
		end
	end

endmodule : sync_2ff

//--- testbench/bay_far_side.sv
// Far-side model of the bay connector: presence pins and removal button
`timescale 1ns/100ps

module bay_far_side (
	input  wire logic clk_i,
	output logic      serial_device_present_o,
	output logic      firewire_device_present_o,
	output logic      remove_btn_o
);

	// ======================================================================
	// Pin levels
	// Pins start idle so nothing looks inserted before the test asks
	initial begin
		serial_device_present_o   = 1'b0;
		firewire_device_present_o = 1'b0;
		remove_btn_o    = 1'b0;
	end

	// Both contacts move on one edge, like a bay connector seating
	task automatic set_pins(input logic ser, input logic fw);
		@(posedge clk_i);
		serial_device_present_o   <= ser;
		firewire_device_present_o <= fw;
	endtask : set_pins

	// Press held for several cycles so the synchroniser cannot miss it
	task automatic press_button();
		@(posedge clk_i);
		remove_btn_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		remove_btn_o <= 1'b0;
	endtask : press_button

endmodule : bay_far_side

//--- testbench/test_bay_state_machine.sv
// Self-checking testbench for the bay hot-plug state machine
`timescale 1ns/100ps

module test_bay_state_machine;

	// ======================================================================
	// Signals
	logic        clk_i     = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ser_device_present;
	logic        fw_device_present;
	logic        btn;
	logic [2:0]  state;
	logic        irq;
	int          n_fail    = 0;
	int          tests_run = 0;
	logic [2:0]  codes [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h5, 3'h7};
	logic [2:0]  exps  [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4};

	// ======================================================================
	// Clock, design and far side
	always #50 clk_i = ~clk_i;

	// Short debounce keeps the run brief; removal still beats expiry
	bay_state_machine #(.DEBOUNCE_CYCLES(20)) dut (
		.clk_i          (clk_i),
		.sys_rst_i      (sys_rst_i),
		.psel_i         (psel),
		.penable_i      (penable),
		.pwrite_i       (pwrite),
		.paddr_i        (paddr),
		.pwdata_i       (pwdata),
		.prdata_o       (prdata),
		.pready_o       (pready),
		.pslverr_o      (pslverr),
		.serial_device_present_i  (ser_device_present),
		.firewire_device_present_i(fw_device_present),
		.remove_btn_i   (btn),
		.bay_state_o    (state),
		.irq_o          (irq)
	);

	bay_far_side far (
		.clk_i          (clk_i),
		.serial_device_present_o  (ser_device_present),
		.firewire_device_present_o(fw_device_present),
		.remove_btn_o   (btn)
	);

	// ======================================================================
	// Helpers
	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Values read right after the edge are the ones the edge sampled
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] rd,
			output logic err);
		int n;
		n = 0;
		@(posedge clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// A slave that never answers counts against the run
		chk("pready", 32'h1, {31'h0, pready});
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
		chk("write error", 32'h0, {31'h0, err});
	endtask : wr

	task automatic rd_chk(input string nm, input logic [7:0] a,
			input logic [31:0] e);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		chk(nm, e, rd);
	endtask : rd_chk

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle

	// Bounded wait; a state that never comes shows as a mismatch
	task automatic wait_state(input logic [2:0] c, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (state !== c && n < lim);
		chk("bay state", {29'h0, c}, {29'h0, state});
	endtask : wait_state

	function automatic logic [31:0] ctl(input logic dsc, input logic rrq,
			input logic [2:0] code);
		ctl = {25'h0, code, rrq, dsc, 2'h0};
	endfunction : ctl

	// ======================================================================
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		tally_and_finish();
	end

	// ======================================================================
	// Test sequence
	initial begin
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd_chk("state reg", bay_pkg::STATE_OFF, 32'h0);
		rd_chk("control reg", bay_pkg::CONTROL_OFF, 32'h0);
		// Requests into an empty bay must be dropped
		wr(bay_pkg::CONTROL_OFF, ctl(1'b0, 1'b0, 3'h2));
		idle(3);
		chk("bay state", 32'h0, {29'h0, state});
		// Enable clear: present device leaves the bay empty
		far.set_pins(1'b1, 1'b0);
		idle(40);
		chk("bay state", 32'h0, {29'h0, state});
		rd_chk("status reg", bay_pkg::STATUS_OFF, 32'h1);
		// Codes 0 to 5 and 7, including the illegal targets, from where it stands
		for (int i = 0; i < 7; i++) begin
			wr(bay_pkg::CONTROL_OFF, ctl(1'b0, 1'b0, codes[i]));
			idle(2);
			chk("bay state", {29'h0, exps[i]}, {29'h0, state});
		end
		// The last field value stays stored but never acts by itself
		rd_chk("control reg", bay_pkg::CONTROL_OFF, 32'h70);
		far.set_pins(1'b0, 1'b0);
		wait_state(bay_pkg::CODE_EMPTY, 10);
		wr(bay_pkg::IRQ_STS_OFF, 32'h7);
		// Hardware insertion with the enable set and the interrupt unmasked
		wr(bay_pkg::CONTROL_OFF, ctl(1'b1, 1'b0, 3'h0));
		wr(bay_pkg::IRQ_MASK_OFF, 32'h1);
		far.set_pins(1'b0, 1'b1);
		wait_state(bay_pkg::CODE_DEBOUNCE, 10);
		wait_state(bay_pkg::CODE_INSERTED, 60);
		rd_chk("status reg", bay_pkg::STATUS_OFF, 32'h6);
		chk("irq", 32'h1, {31'h0, irq});
		wr(bay_pkg::STATUS_OFF, 32'h4);
		wr(bay_pkg::IRQ_STS_OFF, 32'h1);
		idle(2);
		chk("irq", 32'h0, {31'h0, irq});
		rd_chk("status reg", bay_pkg::STATUS_OFF, 32'h2);
		// Pull out of the inserted bay, then again during debounce
		far.set_pins(1'b0, 1'b0);
		wait_state(bay_pkg::CODE_EMPTY, 10);
		far.set_pins(1'b1, 1'b0);
		wait_state(bay_pkg::CODE_DEBOUNCE, 10);
		far.set_pins(1'b0, 1'b0);
		wait_state(bay_pkg::CODE_EMPTY, 10);
		// Button path through to normal removal
		far.set_pins(1'b1, 1'b1);
		wait_state(bay_pkg::CODE_INSERTED, 60);
		wr(bay_pkg::CONTROL_OFF, ctl(1'b1, 1'b1, 3'h2));
		wait_state(bay_pkg::CODE_ENABLED, 3);
		far.press_button();
		wait_state(bay_pkg::CODE_REMREQ, 10);
		rd_chk("status reg", bay_pkg::STATUS_OFF, 32'hf);
		// Two falls, one insertion and the press since the last clear
		rd_chk("irq status", bay_pkg::IRQ_STS_OFF, 32'h7);
		rd_chk("irq mask", bay_pkg::IRQ_MASK_OFF, 32'h1);
		wr(bay_pkg::CONTROL_OFF, ctl(1'b1, 1'b1, 3'h4));
		wait_state(bay_pkg::CODE_ALLOWED, 3);
		rd_chk("state reg", bay_pkg::STATE_OFF, 32'h4);
		far.set_pins(1'b0, 1'b0);
		wait_state(bay_pkg::CODE_EMPTY, 10);
		// Unmapped address is refused
		begin
			logic [31:0] rd;
			logic        err;
			apb(1'b0, 8'h20, 32'h0, rd, err);
			chk("unmapped error", 32'h1, {31'h0, err});
			chk("unmapped data", 32'h0, rd);
		end
		tally_and_finish();
	end

endmodule : test_bay_state_machine
